// ==== shared/spsf_pkg.sv ====
// constants shared by the serial port status flag block
package spsf_pkg;
    localparam int ADDR_W = 18;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_DATA = 16'h0000;
    localparam logic [15:0] IDX_STATUS = 16'h0001;
    localparam logic [15:0] IDX_CTRL2 = 16'h0002;
    localparam logic [15:0] IDX_CTRL3 = 16'h0003;
    localparam logic [15:0] IDX_BRK_CTRL = 16'hFE03;
    // serial_status_one fields
    localparam int ST_TE = 7;
    localparam int ST_TXC = 6;
    localparam int ST_RF = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OR = 3;
    // serial_control_two fields
    localparam int C2_TE_IE = 7;
    localparam int C2_TXC_IE = 6;
    localparam int C2_RF_IE = 5;
    localparam int C2_IL_IE = 4;
    localparam int C2_TX_EN = 3;
    localparam int C2_RX_EN = 2;
    // serial_control_three and break_flag_control fields
    localparam int C3_OR_IE = 0;
    localparam int BRK_CLR_EN = 7;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] CTRL3_RESET = 8'h00;
    localparam logic [7:0] BRK_CTRL_RESET = 8'h00;
    // oversampling and framing
    localparam int OS_RATE = 16;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam int FRAME_BITS = 10;
    localparam int IDLE_BITS = 10;
    localparam logic [7:0] IDLE_TICKS = 8'(IDLE_BITS * OS_RATE);
    localparam int CLK_HZ = 50000000;
    localparam int BAUD_HZ = 115200;
    localparam int OS_DIV = CLK_HZ / (BAUD_HZ * OS_RATE);
endpackage

// ==== shared/spsf_rx_if.sv ====
// link between the flag controller and the receive engine
interface spsf_rx_if;
    logic tick;
    logic rx_enable;
    logic char_valid;
    logic idle_pulse;
    logic [7:0] char_data;
    modport ctrl(output tick, output rx_enable, input char_valid, input idle_pulse, input char_data);
    modport rx(input tick, input rx_enable, output char_valid, output idle_pulse, output char_data);
endinterface

// ==== rtl/spsf_rx.sv ====
// receive engine: line synchroniser, character framing and idle-line detection
module spsf_rx
    import spsf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rxd,
    spsf_rx_if.rx link
);
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } spsf_rxst_e;

    spsf_rxst_e state_reg;
    logic sync1_reg;
    logic line_reg;
    logic [3:0] os_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] ones_reg;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_reg <= 1'b1;
            line_reg <= 1'b1;
        end else begin
            sync1_reg <= i_rxd;
            line_reg <= sync1_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= RX_IDLE;
            os_reg <= 4'h0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            link.char_valid <= 1'b0;
            link.char_data <= 8'h00;
        end else begin
            link.char_valid <= 1'b0;
            if (!link.rx_enable) begin
                state_reg <= RX_IDLE;
            end else if (link.tick) begin
                os_reg <= os_reg + 4'h1;
                case (state_reg)
                    RX_IDLE: begin
                        os_reg <= 4'h0;
                        if (!line_reg) begin
                            state_reg <= RX_START;
                        end
                    end
                    RX_START: begin
                        // a glitch shorter than half a bit is not a start bit
                        if (os_reg == OS_MID) begin
                            os_reg <= 4'h0;
                            bit_reg <= 3'h0;
                            state_reg <= line_reg ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (os_reg == OS_LAST) begin
                            shift_reg <= {line_reg, shift_reg[7:1]};
                            bit_reg <= bit_reg + 3'h1;
                            if (bit_reg == 3'h7) begin
                                state_reg <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        // framing errors are dropped silently
                        if (os_reg == OS_LAST) begin
                            state_reg <= RX_IDLE;
                            link.char_valid <= line_reg;
                            if (line_reg) begin
                                link.char_data <= shift_reg;
                            end
                        end
                    end
                    default: state_reg <= RX_IDLE;
                endcase
            end
        end
    end

    // counts ones in oversample ticks; one pulse per idle stretch
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ones_reg <= 8'h00;
            link.idle_pulse <= 1'b0;
        end else begin
            link.idle_pulse <= 1'b0;
            if (!link.rx_enable || !line_reg) begin
                ones_reg <= 8'h00;
            end else if (link.tick && ones_reg != IDLE_TICKS) begin
                ones_reg <= ones_reg + 8'h01;
                link.idle_pulse <= (ones_reg == IDLE_TICKS - 8'h01); // [RQ10]
            end
        end
    end
endmodule

// ==== rtl/spsf_top.sv ====
// serial port with status flags, two-step flag clearing and break protection
// What this block does
// RQ1: transmit-empty sets when data moves to shifter; reset sets it.
// RQ2: transmit-empty with its enable requests a transmitter interrupt.
// RQ3: transmit-empty clears only by status read seeing it, then data write.
// RQ4: transmission-complete sets when empty and nothing shifting; reset sets it.
// RQ5: transmission-complete with its enable requests a transmitter interrupt.
// RQ6: transmission-complete clears automatically when data is queued.
// RQ7: receive-full sets when a character lands in data register; reset clears.
// RQ8: receive-full with its enable requests a receiver interrupt.
// RQ9: receive-full clears by status read seeing it, then data read.
// RQ10: idle sets after ten consecutive one bit times; reset clears.
// RQ11: idle with its enable requests a receiver interrupt.
// RQ12: idle clears by status read seeing it, then data read.
// RQ13: idle waits for a received character after enable and after clear.
// RQ14: overrun sets when a character completes while receive-full is set.
// RQ15: overrun with its enable in control three requests error interrupt.
// RQ16: on overrun the new character is dropped, held data kept.
// RQ17: overrun clears by status read seeing it, then data read; reset clears.
// RQ18: a data read clears overrun only if the status read saw it set.
// RQ19: in break with clear-enable low, accesses leave flags unchanged, except a data write still clears transmission-complete.
// RQ20: with clear-enable high, flags cleared in break stay cleared.
// RQ21: a first clear step before break survives the break, second completes.
module spsf_top
    import spsf_pkg::*;
#(
    parameter int OS_DIVIDER = OS_DIV
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_break_active,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_tx_irq,
    output logic o_rx_irq,
    output logic o_err_irq
);
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } spsf_txst_e;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    spsf_rx_if rx_link ();

    logic [15:0] div_reg;
    logic tick;
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl3_reg;
    logic [7:0] brk_ctrl_reg;
    logic [7:0] rx_data_reg;
    logic [7:0] tx_data_reg;
    logic tx_pending_reg;
    spsf_txst_e tx_state_reg;
    logic [9:0] tx_shift_reg;
    logic [3:0] tx_os_reg;
    logic [3:0] tx_bit_reg;
    logic te_reg;
    logic txc_reg;
    logic rf_reg;
    logic idle_reg;
    logic or_reg;
    logic idle_allow_reg;
    logic rx_en_prev_reg;
    logic arm_te_reg;
    logic arm_rf_reg;
    logic arm_idle_reg;
    logic arm_or_reg;
    logic [7:0] status;
    logic mapped;
    logic access;
    logic protect;
    logic status_rd;
    logic data_rd;
    logic data_wr;
    logic load_shift;
    logic rf_set;
    logic clr_idle;

    // oversample enable; the transmitter uses every sixteenth one
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_reg <= 16'h0000;
        end else if (div_reg == 16'(OS_DIVIDER - 1)) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end
    assign tick = (div_reg == 16'h0000);

    assign rx_link.tick = tick;
    assign rx_link.rx_enable = ctrl2_reg[C2_RX_EN];

    spsf_rx u_rx (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_rxd(i_rxd),
        .link(rx_link)
    );

    // apb decode; the slave never inserts wait states
    assign mapped = hit(i_paddr, IDX_DATA) || hit(i_paddr, IDX_STATUS) || hit(i_paddr, IDX_CTRL2)
        || hit(i_paddr, IDX_CTRL3) || hit(i_paddr, IDX_BRK_CTRL);
    assign access = i_psel && i_penable;
    assign o_pready = access;
    assign o_pslverr = access && !mapped;

    assign protect = i_break_active && !brk_ctrl_reg[BRK_CLR_EN]; // [RQ19] [RQ20]
    assign status_rd = access && !i_pwrite && hit(i_paddr, IDX_STATUS) && !protect;
    assign data_rd = access && !i_pwrite && hit(i_paddr, IDX_DATA) && !protect;
    assign data_wr = access && i_pwrite && hit(i_paddr, IDX_DATA);

    assign status = {te_reg, txc_reg, rf_reg, idle_reg, or_reg, 3'b000};

    // read data is captured in the setup cycle, so a status read arms on what software saw
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            if (hit(i_paddr, IDX_DATA)) begin
                o_prdata <= {24'h000000, rx_data_reg};
            end else if (hit(i_paddr, IDX_STATUS)) begin
                o_prdata <= {24'h000000, status};
            end else if (hit(i_paddr, IDX_CTRL2)) begin
                o_prdata <= {24'h000000, ctrl2_reg};
            end else if (hit(i_paddr, IDX_CTRL3)) begin
                o_prdata <= {24'h000000, ctrl3_reg};
            end else if (hit(i_paddr, IDX_BRK_CTRL)) begin
                o_prdata <= {24'h000000, brk_ctrl_reg};
            end else begin
                o_prdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl2_reg <= CTRL2_RESET;
            ctrl3_reg <= CTRL3_RESET;
            brk_ctrl_reg <= BRK_CTRL_RESET;
        end else if (access && i_pwrite) begin
            if (hit(i_paddr, IDX_CTRL2)) begin
                ctrl2_reg <= {i_pwdata[7:2], 2'b00};
            end
            if (hit(i_paddr, IDX_CTRL3)) begin
                ctrl3_reg <= {7'h00, i_pwdata[C3_OR_IE]};
            end
            if (hit(i_paddr, IDX_BRK_CTRL)) begin
                brk_ctrl_reg <= {i_pwdata[BRK_CLR_EN], 7'h00};
            end
        end
    end

    // first step of each clear: armed by a status read that saw the flag set
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            arm_te_reg <= 1'b0;
            arm_rf_reg <= 1'b0;
            arm_idle_reg <= 1'b0;
            arm_or_reg <= 1'b0;
        end else if (status_rd) begin
            arm_te_reg <= o_prdata[ST_TE];
            arm_rf_reg <= o_prdata[ST_RF];
            arm_idle_reg <= o_prdata[ST_IDLE];
            arm_or_reg <= o_prdata[ST_OR]; // [RQ18]
        end else begin
            // protected accesses neither arm nor consume, so an arm survives a break
            if (data_wr && !protect) begin
                arm_te_reg <= 1'b0; // [RQ21]
            end
            if (data_rd) begin
                arm_rf_reg <= 1'b0;
                arm_idle_reg <= 1'b0;
                arm_or_reg <= 1'b0;
            end
        end
    end

    // transmit holding register and shifter
    assign load_shift = tx_pending_reg && tx_state_reg == TX_IDLE && ctrl2_reg[C2_TX_EN];

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_pending_reg <= 1'b0;
            tx_data_reg <= 8'h00;
        end else if (data_wr) begin
            // a write while a byte waits overwrites it
            tx_pending_reg <= 1'b1;
            tx_data_reg <= i_pwdata[7:0];
        end else if (load_shift) begin
            tx_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 10'h3FF;
            tx_os_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (load_shift) begin
                        tx_shift_reg <= {1'b1, tx_data_reg, 1'b0};
                        tx_os_reg <= 4'h0;
                        tx_bit_reg <= 4'h0;
                        tx_state_reg <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tick) begin
                        tx_os_reg <= tx_os_reg + 4'h1;
                        if (tx_os_reg == OS_LAST) begin
                            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                            if (tx_bit_reg == 4'(FRAME_BITS - 1)) begin
                                tx_state_reg <= TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_txd <= 1'b1;
        end else begin
            o_txd <= (tx_state_reg == TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            te_reg <= 1'b1;
        end else if (load_shift) begin
            te_reg <= 1'b1; // [RQ1]
        end else if (data_wr && !protect && arm_te_reg) begin
            te_reg <= 1'b0; // [RQ3]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            txc_reg <= 1'b1;
        end else begin
            // queueing a byte drops it at once; the line starts within a bit time
            txc_reg <= te_reg && tx_state_reg == TX_IDLE && !tx_pending_reg && !data_wr; // [RQ4] [RQ6]
        end
    end

    // receive side flags
    assign rf_set = rx_link.char_valid && !rf_reg;
    assign clr_idle = data_rd && arm_idle_reg;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_data_reg <= 8'h00;
        end else if (rf_set) begin
            rx_data_reg <= rx_link.char_data; // [RQ7] [RQ16]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rf_reg <= 1'b0;
        end else if (rf_set) begin
            rf_reg <= 1'b1; // [RQ7]
        end else if (data_rd && arm_rf_reg) begin
            rf_reg <= 1'b0; // [RQ9]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            or_reg <= 1'b0;
        end else if (rx_link.char_valid && rf_reg) begin
            or_reg <= 1'b1; // [RQ14]
        end else if (data_rd && arm_or_reg) begin
            or_reg <= 1'b0; // [RQ17] [RQ18]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_en_prev_reg <= 1'b0;
            idle_allow_reg <= 1'b0;
        end else begin
            rx_en_prev_reg <= ctrl2_reg[C2_RX_EN];
            if (rf_set) begin
                idle_allow_reg <= 1'b1; // [RQ13]
            end else if (clr_idle || (ctrl2_reg[C2_RX_EN] && !rx_en_prev_reg)) begin
                idle_allow_reg <= 1'b0; // [RQ13]
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            idle_reg <= 1'b0;
        end else if (rx_link.idle_pulse && idle_allow_reg) begin
            idle_reg <= 1'b1; // [RQ10]
        end else if (clr_idle) begin
            idle_reg <= 1'b0; // [RQ12]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_irq <= 1'b0;
            o_rx_irq <= 1'b0;
            o_err_irq <= 1'b0;
        end else begin
            o_tx_irq <= (te_reg && ctrl2_reg[C2_TE_IE]) || (txc_reg && ctrl2_reg[C2_TXC_IE]); // [RQ2] [RQ5]
            o_rx_irq <= (rf_reg && ctrl2_reg[C2_RF_IE]) || (idle_reg && ctrl2_reg[C2_IL_IE]); // [RQ8] [RQ11]
            o_err_irq <= or_reg && ctrl3_reg[C3_OR_IE]; // [RQ15]
        end
    end
endmodule

// ==== test/spsf_assertions.sv ====
// port-level assertions for the serial port status flag block
module spsf_assertions
    import spsf_pkg::*;
#(
    parameter int OS_DIVIDER = OS_DIV
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_break_active,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_tx_irq,
    input wire logic o_rx_irq,
    input wire logic o_err_irq
);
    logic acc;
    logic rd_st;
    logic mapped;
    logic [7:0] c2_reg;
    logic [7:0] c3_reg;
    assign acc = i_psel && i_penable;
    assign rd_st = acc && !i_pwrite && (i_paddr == {IDX_STATUS, 2'b00});
    assign mapped = (i_paddr == {IDX_DATA, 2'b00}) || (i_paddr == {IDX_STATUS, 2'b00}) ||
        (i_paddr == {IDX_CTRL2, 2'b00}) || (i_paddr == {IDX_CTRL3, 2'b00}) || (i_paddr == {IDX_BRK_CTRL, 2'b00});
    // shadow enables so the interrupt levels can be tied to the status snapshot
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            c2_reg <= CTRL2_RESET;
            c3_reg <= CTRL3_RESET;
        end else if (acc && i_pwrite) begin
            if (i_paddr == {IDX_CTRL2, 2'b00}) c2_reg <= i_pwdata[7:0];
            if (i_paddr == {IDX_CTRL3, 2'b00}) c3_reg <= i_pwdata[7:0];
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    a_pready_no_wait: assert property (o_pready == acc)
        else $error("pready differs from psel and penable");
    a_slverr_unmapped: assert property (acc |-> (o_pslverr == !mapped))
        else $error("pslverr wrong for address");
    a_prdata_upper_zero: assert property (o_prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_prdata_holds: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data changed outside read setup");
    a_status_low_zero: assert property (rd_st |-> (o_prdata[2:0] == 3'h0))
        else $error("status low bits not zero");
    a_txc_needs_te: assert property (rd_st |-> (!o_prdata[ST_TXC] || o_prdata[ST_TE]))
        else $error("complete flag without empty flag");
    a_tx_irq_level: assert property (rd_st |-> o_tx_irq ==
        ((o_prdata[ST_TE] && c2_reg[C2_TE_IE]) || (o_prdata[ST_TXC] && c2_reg[C2_TXC_IE])))
        else $error("transmit interrupt does not match flags");
    a_rx_irq_level: assert property (rd_st |-> o_rx_irq ==
        ((o_prdata[ST_RF] && c2_reg[C2_RF_IE]) || (o_prdata[ST_IDLE] && c2_reg[C2_IL_IE])))
        else $error("receive interrupt does not match flags");
    a_err_irq_level: assert property (rd_st |-> (o_err_irq == (o_prdata[ST_OR] && c3_reg[C3_OR_IE])))
        else $error("error interrupt does not match overrun");
    a_release_quiet: assert property ($rose(i_resetn) |-> !o_tx_irq && !o_rx_irq && !o_err_irq && o_txd)
        else $error("outputs not quiet after reset");
    c_overrun_seen: cover property (rd_st && o_prdata[ST_OR]);
endmodule

bind spsf_top spsf_assertions #(.OS_DIVIDER(OS_DIVIDER)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_break_active(i_break_active),
    .i_rxd(i_rxd), .o_txd(o_txd), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_err_irq(o_err_irq));

// ==== test/spsf_peer.sv ====
// remote serial peer: sends 8N1 frames on the receive line and decodes the transmit line
module spsf_peer #(
    parameter int BIT_CLKS = 16
)
(
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial o_rxd = 1'b1;
    task automatic send(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge i_clk);
        end
    endtask
    // a bad stop bit is recorded inverted so the bench sees a mismatch
    always begin
        @(negedge i_txd);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            sh[i] = i_txd;
        end
        repeat (BIT_CLKS) @(posedge i_clk);
        rx_q.push_back(i_txd === 1'b1 ? sh : ~sh);
    end
endmodule

// ==== test/test_serial_port_status_flags.sv ====
// self-checking bench for the serial port status flag block
module test_serial_port_status_flags
    import spsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = OS_RATE;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic brk = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, rxd, txd, tx_irq, rx_irq, err_irq, er;
    int errors = 0;
    int check_count = 0;
    int seed = 86991;
    int m_te = 1, m_txc = 1, m_rf = 0, m_idle = 0, m_or = 0, m_allow = 0, m_dat = 0, m_clr_en = 0;
    int a_rf = 0, a_idle = 0, a_or = 0;
    logic [7:0] b;
    logic [7:0] tx_exp[$];
    logic [15:0] ix[3] = '{IDX_CTRL2, IDX_CTRL3, IDX_BRK_CTRL};
    logic [7:0] rv[3] = '{CTRL2_RESET, CTRL3_RESET, BRK_CTRL_RESET};
    logic [7:0] wv[3] = '{8'h7C, 8'h01, 8'h80};
    always #10 clk = ~clk;
    spsf_top #(.OS_DIVIDER(1)) DUT (.i_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_break_active(brk), .i_rxd(rxd), .o_txd(txd), .o_tx_irq(tx_irq),
        .o_rx_irq(rx_irq), .o_err_irq(err_irq));
    spsf_peer #(.BIT_CLKS(BIT)) peer (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
    task automatic stop_test();
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // status read: compare, then arm what was set unless the break protects the flags
    task automatic status();
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'(m_te * 128 + m_txc * 64 + m_rf * 32 + m_idle * 16 + m_or * 8));
        if (!(brk && m_clr_en == 0)) begin
            a_rf = m_rf;
            a_idle = m_idle;
            a_or = m_or;
        end
    endtask
    task automatic rdata();
        apb(1'b0, IDX_DATA, 8'h00);
        chk(rd, 32'(m_dat));
        if (!(brk && m_clr_en == 0)) begin
            if (a_rf != 0) m_rf = 0;
            if (a_or != 0) m_or = 0;
            if (a_idle != 0) begin
                m_idle = 0;
                m_allow = 0;
            end
            a_rf = 0;
            a_idle = 0;
            a_or = 0;
        end
    endtask
    task automatic recv();
        b = 8'($random(seed));
        peer.send(b);
        repeat (4) @(posedge clk);
        if (m_rf != 0) begin
            m_or = 1;
        end else begin
            m_rf = 1;
            m_dat = b;
            m_allow = 1;
        end
    endtask
    task automatic settle();
        repeat (12 * BIT) @(posedge clk);
        if (m_allow != 0) m_idle = 1;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        status();
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ix[i], 8'h00);
            chk(rd, 32'(rv[i]));
            apb(1'b1, ix[i], wv[i]);
            apb(1'b0, ix[i], 8'h00);
            chk(rd, 32'(wv[i]));
        end
        m_clr_en = 1;
        apb(1'b0, 16'h0010, 8'h00);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        chk(32'(tx_irq), 32'h1);
        status();
        for (int i = 0; i < 2; i++) begin
            b = 8'($random(seed));
            apb(1'b1, IDX_DATA, b);
            tx_exp.push_back(b);
            m_txc = 0;
            m_te = i == 0;
            status();
        end
        chk(32'(tx_irq), 32'h0);
        for (int i = 0; i < 3000 && peer.rx_q.size() < 2; i++) @(posedge clk);
        repeat (2 * BIT) @(posedge clk);
        chk(32'(peer.rx_q.size()), 32'h2);
        m_te = 1;
        m_txc = 1;
        status();
        while (tx_exp.size() > 0) chk(32'(peer.rx_q.pop_front()), 32'(tx_exp.pop_front()));
        recv();
        status();
        chk(32'(rx_irq), 32'h1);
        settle();
        status();
        rdata();
        settle();
        status();
        recv();
        status();
        recv();
        rdata();
        status();
        chk(32'(err_irq), 32'h1);
        rdata();
        settle();
        chk(32'(err_irq), 32'h0);
        status();
        rdata();
        apb(1'b1, IDX_CTRL2, 8'($random(seed)) | 8'h8C);
        status();
        chk(32'(tx_irq), 32'h1);
        brk <= 1'b1;
        recv();
        status();
        rdata();
        brk <= 1'b0;
        status();
        apb(1'b1, IDX_BRK_CTRL, 8'h00);
        m_clr_en = 0;
        recv();
        status();
        brk <= 1'b1;
        status();
        rdata();
        status();
        brk <= 1'b0;
        rdata();
        status();
        stop_test();
    end
endmodule
